// >>> vc11_tu12_map.vh
// Constants for the VC-11 into TU-12 source adaptation: VC-4 frame geometry,
// TU-12 slot layout, pointer word fields and fixed byte values.
// Assumes it is included by bare name from the design files that need it.
`ifndef VC11_TU12_MAP_VH
`define VC11_TU12_MAP_VH

// VC-4 frame geometry, one byte tick per column.
`define VC4_LAST_COLUMN 9'd261
`define VC4_LAST_ROW 4'd9
`define FIRST_INDEX_ONE 4'd1

// Column of TU-12 (1,1,1) and the column steps for K, L, M and the four interleaved columns.
`define TU_FIRST_COLUMN 9'd10
`define K_STEP 9'd1
`define L_STEP 9'd3
`define M_STEP 9'd21
`define TU_COLUMN_STEP 9'd63
`define SLOT_COLUMNS 6'd4

// Frames of the 500 us multiframe, in the order of the V bytes they carry.
`define FRAME_PTR_ONE 2'd0
`define FRAME_PTR_TWO 2'd1
`define FRAME_NEG_OPP 2'd2
`define FRAME_UNDEFINED 2'd3

// Pointer offsets: 140 container bytes per multiframe, 35 per frame.
`define FRAME_PAYLOAD 8'd35
`define LAST_POINTER 10'd139
`define POS_OPPORTUNITY_ONE 6'd1

// Fixed stuff inside each 35 byte quarter of the VC-11, counted from its overhead byte.
`define QUARTER_LAST 6'd34
`define STUFF_FIRST 6'd17
`define STUFF_LAST 6'd25

// Pointer word fields.
`define SIZE_FIELD 2'b10
`define NDF_NORMAL 4'h6
`define NDF_NEW 4'h9
`define INVERT_INCREMENT 10'h2aa
`define INVERT_DECREMENT 10'h155

// Fixed byte values: stuff has even parity, all ones is the alarm pattern.
`define FIXED_STUFF_BYTE 8'h00
`define UNDEFINED_BYTE 8'h00
`define ALL_ONES_BYTE 8'hff
`define LAST_BIT_OF_BYTE 3'd7

`endif

// >>> elastic_store_ram.v
// Small two-port memory holding the elastic store words of the tributary.
// Assumes one clock for both ports; read data comes out of a register one cycle later.
module elastic_store_ram #(
    parameter WIDTH = 9,
    parameter ADDR_BITS = 4
) (
    input wire clock,
    input wire reset,
    input wire write_enable,
    input wire [ADDR_BITS-1:0] write_address,
    input wire [WIDTH-1:0] write_data,
    input wire [ADDR_BITS-1:0] read_address,
    output reg [WIDTH-1:0] read_data
);

    reg [WIDTH-1:0] storage [0:(1<<ADDR_BITS)-1];

    // Write port stores a word; the memory array itself needs no reset.
    always @(posedge clock) begin
        if (write_enable) begin
            storage[write_address] <= write_data;
        end
    end

    // Read port follows the read address continuously with one cycle of latency.
    always @(posedge clock) begin
        if (reset) begin
            read_data <= {WIDTH{1'b0}};
        end else begin
            read_data <= storage[read_address];
        end
    end

endmodule // elastic_store_ram

// >>> vc11_into_tu12_adapt_source.v
// Source adaptation of a bit serial VC-11 stream into one TU-12 slot of a VC-4.
// Assumes every link pin is asynchronous to clock and is sampled by two flip-flops;
// the slot indices and activation are static configuration on the clock domain.
//
// Notes on behaviour
// - Write tributary bytes and frame marks into store.
// - Read store on VC-4 byte ticks and justification.
// - Positive justification leaves V3+1 empty once.
// - Negative justification puts extra byte in V3.
// - Only pointer moves absorb offset; pointer carries phase.
// - Add nine fixed stuff bytes per frame.
// - Fixed stuff bytes carry even parity.
// - Overhead positions follow the VC-11 start.
// - First overhead byte sits where pointer says.
// - Pointer goes in first two V bytes.
// - Standard pointer generation, size field 10.
// - Fourth V byte carries any value.
// - Serve one slot chosen by K, L, M.
// - Drive slot only while activation is true.
// - Alarm follows upstream fail; open input false.
// - Alarm forces all ones within 1000 us.
// - Clearing alarm restores data within 1000 us.
`include "vc11_tu12_map.vh"

module vc11_into_tu12_adapt_source #(
    parameter DEPTH_LOG2 = 4,
    parameter FILL_LOW = 4,
    parameter FILL_HIGH = 12
) (
    input wire clock,
    input wire reset,
    input wire tributary_clock_in,
    input wire tributary_data_in,
    input wire tributary_frame_start_in,
    input wire upstream_signal_fail_in,
    input wire higher_order_clock_in,
    input wire higher_order_frame_start,
    input wire higher_order_multiframe_start,
    input wire slot_activation_control,
    input wire [1:0] slot_k,
    input wire [2:0] slot_l,
    input wire [1:0] slot_m,
    output reg [7:0] slot_data_out,
    output reg slot_data_enable,
    output reg alarm_indication_action,
    output reg pointer_locked,
    output reg [9:0] pointer_value
);

    localparam ST_HUNT = 1'b0;
    localparam ST_LOCKED = 1'b1;
    localparam [DEPTH_LOG2:0] FILL_FULL = 1 << DEPTH_LOG2;
    localparam [DEPTH_LOG2:0] FILL_LOW_W = FILL_LOW;
    localparam [DEPTH_LOG2:0] FILL_HIGH_W = FILL_HIGH;

    // Returns hit and interleave column number when a VC-4 column belongs to slot K.L.M.
    function [2:0] slot_hit;
        input [8:0] column;
        input [1:0] k;
        input [2:0] l;
        input [1:0] m;
        reg [8:0] candidate;
        integer i;
        begin
            slot_hit = 3'b000;
            candidate = `TU_FIRST_COLUMN + ({7'd0, k} - 9'd1) * `K_STEP
                + ({6'd0, l} - 9'd1) * `L_STEP + ({7'd0, m} - 9'd1) * `M_STEP;
            for (i = 0; i < 4; i = i + 1) begin
                if (column == candidate) begin
                    slot_hit = {1'b1, i[1:0]};
                end
                candidate = candidate + `TU_COLUMN_STEP;
            end
        end
    endfunction

    // Two flip-flop synchronisers for every pin coming from outside the clock domain.
    reg tck_s1, tck_s2, tck_d;
    reg tdat_s1, tdat_s2;
    reg tfs_s1, tfs_s2;
    reg hck_s1, hck_s2, hck_d;
    reg hfs_s1, hfs_s2;
    reg hmfs_s1, hmfs_s2;
    reg fail_s1, fail_s2;

    always @(posedge clock) begin
        if (reset) begin
            {tck_s1, tck_s2, tck_d, tdat_s1, tdat_s2, tfs_s1, tfs_s2} <= 7'h00;
            {hck_s1, hck_s2, hck_d, hfs_s1, hfs_s2, hmfs_s1, hmfs_s2} <= 7'h00;
            {fail_s1, fail_s2} <= 2'b00;
        end else begin
            tck_s1 <= tributary_clock_in;
            tck_s2 <= tck_s1;
            tck_d <= tck_s2;
            tdat_s1 <= tributary_data_in;
            tdat_s2 <= tdat_s1;
            tfs_s1 <= tributary_frame_start_in;
            tfs_s2 <= tfs_s1;
            hck_s1 <= higher_order_clock_in;
            hck_s2 <= hck_s1;
            hck_d <= hck_s2;
            hfs_s1 <= higher_order_frame_start;
            hfs_s2 <= hfs_s1;
            hmfs_s1 <= higher_order_multiframe_start;
            hmfs_s2 <= hmfs_s1;
            fail_s1 <= upstream_signal_fail_in;
            fail_s2 <= fail_s1;
        end
    end

    wire trib_tick = tck_s2 & ~tck_d;
    wire ho_tick = hck_s2 & ~hck_d;

    // Tributary side: bits assemble MSB first into bytes; a frame start realigns the byte.
    reg [2:0] bit_count;
    reg [6:0] bit_shift;
    reg start_mark;
    reg store_write;
    reg [8:0] store_word;

    always @(posedge clock) begin
        if (reset) begin
            bit_count <= 3'd0;
            bit_shift <= 7'h00;
            start_mark <= 1'b0;
            store_write <= 1'b0;
            store_word <= 9'h000;
        end else begin
            store_write <= 1'b0;
            if (trib_tick) begin
                if (tfs_s2) begin
                    bit_shift <= {6'h00, tdat_s2};
                    bit_count <= 3'd1;
                    start_mark <= 1'b1;
                end else if (bit_count == `LAST_BIT_OF_BYTE) begin
                    store_write <= 1'b1;
                    store_word <= {start_mark, bit_shift, tdat_s2};
                    start_mark <= 1'b0;
                    bit_count <= 3'd0;
                end else begin
                    bit_shift <= {bit_shift[5:0], tdat_s2};
                    bit_count <= bit_count + 3'd1;
                end
            end
        end
    end

    // Elastic store pointers and fill level; a write into a full store is dropped.
    reg [DEPTH_LOG2-1:0] write_address;
    reg [DEPTH_LOG2-1:0] read_address;
    reg [DEPTH_LOG2:0] fill;
    reg pop;
    wire [8:0] head_word;
    wire push = store_write && (fill != FILL_FULL);
    wire store_empty = (fill == {(DEPTH_LOG2+1){1'b0}});

    elastic_store_ram #(.WIDTH(9), .ADDR_BITS(DEPTH_LOG2)) store (
        .clock(clock),
        .reset(reset),
        .write_enable(push),
        .write_address(write_address),
        .write_data(store_word),
        .read_address(read_address),
        .read_data(head_word)
    );

    always @(posedge clock) begin
        if (reset) begin
            write_address <= {DEPTH_LOG2{1'b0}};
            read_address <= {DEPTH_LOG2{1'b0}};
            fill <= {(DEPTH_LOG2+1){1'b0}};
        end else begin
            if (push) begin
                write_address <= write_address + 1'b1;
            end
            if (pop) begin
                read_address <= read_address + 1'b1;
            end
            fill <= fill + {{DEPTH_LOG2{1'b0}}, push} - {{DEPTH_LOG2{1'b0}}, pop};
        end
    end

    // VC-4 position: column, row and multiframe frame, advanced on each byte tick.
    reg [8:0] column;
    reg [3:0] row;
    reg [1:0] frame;
    reg process_byte;

    always @(posedge clock) begin
        if (reset) begin
            column <= 9'd0;
            row <= 4'd0;
            frame <= 2'd0;
            process_byte <= 1'b0;
        end else begin
            process_byte <= ho_tick;
            if (ho_tick) begin
                if (hfs_s2) begin
                    column <= 9'd1;
                    row <= `FIRST_INDEX_ONE;
                    frame <= hmfs_s2 ? `FRAME_PTR_ONE : frame + 2'd1;
                end else if (column == `VC4_LAST_COLUMN) begin
                    column <= 9'd1;
                    row <= (row == `VC4_LAST_ROW) ? `FIRST_INDEX_ONE : row + 4'd1;
                end else begin
                    column <= column + 9'd1;
                end
            end
        end
    end

    // Slot byte decode: byte index within the frame and pointer offset of the byte.
    wire [2:0] hit = slot_hit(column, slot_k, slot_l, slot_m);
    wire [5:0] slot_index = ({2'd0, row} - 6'd1) * `SLOT_COLUMNS + {4'd0, hit[1:0]};
    wire [1:0] frame_after_two = frame - `FRAME_PTR_TWO;
    wire [7:0] byte_offset = {6'd0, frame_after_two} * `FRAME_PAYLOAD + {2'd0, slot_index} - 8'd1;
    wire in_slot = process_byte && hit[2];
    wire v_byte = (slot_index == 6'd0);
    wire opportunity_one = (frame == `FRAME_NEG_OPP) && (slot_index == `POS_OPPORTUNITY_ONE);

    // Justification decision from the fill level taken once per multiframe at the first V byte.
    wire decide_inc = (fill < FILL_LOW_W);
    wire decide_dec = (fill > FILL_HIGH_W);
    wire [9:0] pointer_mask = decide_inc ? `INVERT_INCREMENT : (decide_dec ? `INVERT_DECREMENT : 10'h000);

    reg state;
    reg just_inc;
    reg just_dec;
    reg new_data;
    reg [9:0] sent_pointer;
    reg [5:0] quarter;

    // Byte generator: pointer bytes, justification, stuff, payload and the alarm pattern.
    always @(posedge clock) begin
        if (reset) begin
            state <= ST_HUNT;
            just_inc <= 1'b0;
            just_dec <= 1'b0;
            new_data <= 1'b1;
            sent_pointer <= 10'h000;
            quarter <= 6'd0;
            pop <= 1'b0;
            slot_data_out <= `ALL_ONES_BYTE;
            slot_data_enable <= 1'b0;
            alarm_indication_action <= 1'b0;
            pointer_locked <= 1'b0;
            pointer_value <= 10'h000;
        end else begin
            pop <= 1'b0;
            alarm_indication_action <= fail_s2;
            pointer_locked <= (state == ST_LOCKED);
            slot_data_enable <= in_slot && slot_activation_control;
            if (in_slot) begin
                if (alarm_indication_action) begin
                    state <= ST_HUNT;
                    new_data <= 1'b1;
                    just_inc <= 1'b0;
                    just_dec <= 1'b0;
                    slot_data_out <= `ALL_ONES_BYTE;
                end else begin
                    case (state)
                        ST_HUNT: begin
                            slot_data_out <= `ALL_ONES_BYTE;
                            if (!v_byte && !store_empty) begin
                                pop <= 1'b1;
                                if (head_word[8]) begin
                                    state <= ST_LOCKED;
                                    pointer_value <= {2'd0, byte_offset};
                                    slot_data_out <= head_word[7:0];
                                    quarter <= 6'd1;
                                end
                            end
                        end
                        ST_LOCKED: begin
                            if (v_byte) begin
                                case (frame)
                                    `FRAME_PTR_ONE: begin
                                        just_inc <= decide_inc;
                                        just_dec <= decide_dec && !decide_inc;
                                        sent_pointer <= pointer_value ^ pointer_mask;
                                        new_data <= 1'b0;
                                        slot_data_out <= {new_data ? `NDF_NEW : `NDF_NORMAL, `SIZE_FIELD,
                                            pointer_value[9:8] ^ pointer_mask[9:8]};
                                    end
                                    `FRAME_PTR_TWO: begin
                                        slot_data_out <= sent_pointer[7:0];
                                    end
                                    `FRAME_NEG_OPP: begin
                                        if (just_dec) begin
                                            just_dec <= 1'b0;
                                            pointer_value <= (pointer_value == 10'h000) ? `LAST_POINTER
                                                : pointer_value - 10'd1;
                                            if (quarter >= `STUFF_FIRST && quarter <= `STUFF_LAST) begin
                                                slot_data_out <= `FIXED_STUFF_BYTE;
                                            end else if (store_empty) begin
                                                state <= ST_HUNT;
                                                new_data <= 1'b1;
                                                slot_data_out <= `ALL_ONES_BYTE;
                                            end else begin
                                                slot_data_out <= head_word[7:0];
                                                pop <= 1'b1;
                                            end
                                            quarter <= (quarter == `QUARTER_LAST) ? 6'd0 : quarter + 6'd1;
                                        end else begin
                                            slot_data_out <= `FIXED_STUFF_BYTE;
                                        end
                                    end
                                    default: begin
                                        slot_data_out <= `UNDEFINED_BYTE;
                                    end
                                endcase
                            end else if (opportunity_one && just_inc) begin
                                just_inc <= 1'b0;
                                slot_data_out <= `FIXED_STUFF_BYTE;
                                pointer_value <= (pointer_value == `LAST_POINTER) ? 10'h000
                                    : pointer_value + 10'd1;
                            end else if (quarter >= `STUFF_FIRST && quarter <= `STUFF_LAST) begin
                                slot_data_out <= `FIXED_STUFF_BYTE;
                                quarter <= quarter + 6'd1;
                            end else if (store_empty || (head_word[8] && quarter != 6'd0)) begin
                                state <= ST_HUNT;
                                new_data <= 1'b1;
                                slot_data_out <= `ALL_ONES_BYTE;
                            end else begin
                                slot_data_out <= head_word[7:0];
                                pop <= 1'b1;
                                quarter <= (quarter == `QUARTER_LAST) ? 6'd0 : quarter + 6'd1;
                            end
                        end
                        default: begin
                            state <= ST_HUNT;
                        end
                    endcase
                end
            end
        end
    end

endmodule // vc11_into_tu12_adapt_source

// >>> vc11_into_tu12_adapt_source_properties.sv
// Concurrent checks for the VC-11 into TU-12 source adaptation, on its top ports only.
// Assumes byte ticks at least four clocks apart and a synchronous active high reset.
module vc11_into_tu12_adapt_source_properties (
    input wire clock,
    input wire reset,
    input wire upstream_signal_fail_in,
    input wire slot_activation_control,
    input wire [7:0] slot_data_out,
    input wire slot_data_enable,
    input wire alarm_indication_action,
    input wire pointer_locked,
    input wire [9:0] pointer_value
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    int unsigned alarm_age;
    int unsigned pointer_age;
    reg [9:0] last_pointer;
    // Ages of the alarm and of the pointer value, saturating so they never wrap.
    always @(posedge clock) begin
        if (reset || !alarm_indication_action) begin
            alarm_age <= 0;
        end else if (alarm_age < 1000) begin
            alarm_age <= alarm_age + 1;
        end
        if (reset || !pointer_locked) begin
            pointer_age <= 100000;
        end else if (pointer_value != last_pointer) begin
            pointer_age <= 0;
        end else if (pointer_age < 100000) begin
            pointer_age <= pointer_age + 1;
        end
        last_pointer <= pointer_value;
    end
    single_pulse_a: assert property (slot_data_enable |=> !slot_data_enable [*3])
        else $error("slot enable lasted more than one cycle");
    idle_slot_quiet_a: assert property ((!slot_activation_control) [*4] |-> !slot_data_enable)
        else $error("slot driven while inactive");
    alarm_raise_a: assert property (upstream_signal_fail_in [*8] |-> alarm_indication_action)
        else $error("alarm did not follow fail input");
    alarm_clear_a: assert property ((!upstream_signal_fail_in) [*8] |-> !alarm_indication_action)
        else $error("alarm stayed without fail input");
    alarm_all_ones_a: assert property (alarm_age > 64 && slot_data_enable |-> slot_data_out == 8'hff)
        else $error("slot byte not all ones under alarm");
    alarm_forces_hunt_a: assert property (alarm_age > 300 |-> !pointer_locked)
        else $error("generator locked under alarm");
    pointer_range_a: assert property (pointer_value <= 10'd139)
        else $error("pointer offset out of range");
    one_action_a: assert property (pointer_locked && $past(pointer_locked) && pointer_value != last_pointer
        |-> pointer_age > 30000)
        else $error("pointer moved twice in one multiframe");
    cover property (slot_data_enable && slot_activation_control);
    cover property (alarm_age > 64 && slot_data_enable);
    cover property ($rose(pointer_locked));
endmodule // vc11_into_tu12_adapt_source_properties

bind vc11_into_tu12_adapt_source vc11_into_tu12_adapt_source_properties checker_inst (
    .clock(clock),
    .reset(reset),
    .upstream_signal_fail_in(upstream_signal_fail_in),
    .slot_activation_control(slot_activation_control),
    .slot_data_out(slot_data_out),
    .slot_data_enable(slot_data_enable),
    .alarm_indication_action(alarm_indication_action),
    .pointer_locked(pointer_locked),
    .pointer_value(pointer_value)
);

// >>> vc4_and_tributary_model.sv
// Far side model: VC-4 byte clock with frame and multiframe starts, and a paced
// bit serial VC-11 source. Assumes a 50 MHz clock and synchronous active high reset.
module vc4_and_tributary_model (
    input wire clock,
    input wire reset,
    output reg higher_order_clock_in = 1'b0,
    output reg higher_order_frame_start = 1'b1,
    output reg higher_order_multiframe_start = 1'b1,
    output reg tributary_clock_in,
    output reg tributary_data_in,
    output reg tributary_frame_start_in,
    output reg frame_mark = 1'b0,
    output reg multiframe_mark = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [1:0] phase;
    reg [11:0] column;
    reg [1:0] frame;
    reg [6:0] gap;
    int credit;
    int sent;
    reg [7:0] value;
    // Byte ticks every four clocks; starts change only while the byte clock is low.
    always @(posedge clock) begin
        if (reset) begin
            phase <= 2'd0;
            column <= 12'd0;
            frame <= 2'd0;
            gap <= 7'd0;
            credit <= 11;
            higher_order_clock_in <= 1'b0;
            higher_order_frame_start <= 1'b1;
            higher_order_multiframe_start <= 1'b1;
        end else begin
            phase <= phase + 2'd1;
            higher_order_clock_in <= (phase == 2'd3) || (phase == 2'd0);
            frame_mark <= (phase == 2'd3) && higher_order_frame_start;
            multiframe_mark <= (phase == 2'd3) && higher_order_multiframe_start;
            if (phase == 2'd1) begin
                column <= (column == 12'd2348) ? 12'd0 : column + 12'd1;
                frame <= (column == 12'd2348) ? frame + 2'd1 : frame;
                higher_order_frame_start <= (column == 12'd2348);
                higher_order_multiframe_start <= (column == 12'd2348) && (frame == 2'd3);
                gap <= (gap == 7'd89) ? 7'd0 : gap + 7'd1;
                if (gap == 7'd89) begin
                    credit <= credit + 1;
                end
            end
        end
    end
    // Sends granted bytes MSB first; the bit clock stands still while no byte is granted.
    initial begin
        tributary_clock_in = 1'b0;
        tributary_data_in = 1'b0;
        tributary_frame_start_in = 1'b0;
        sent = 0;
        #37;
        forever begin
            if (reset !== 1'b0 || sent >= credit) begin
                #80;
            end else begin
                value = (sent % 104 == 0) ? 8'hc3 : 8'h5a;
                for (int b = 7; b >= 0; b--) begin
                    tributary_data_in = value[b];
                    tributary_frame_start_in = (sent % 104 == 0) && (b == 7);
                    #80 tributary_clock_in = 1'b1;
                    #80 tributary_clock_in = 1'b0;
                end
                tributary_data_in = ~value[0];
                tributary_frame_start_in = 1'b0;
                sent = sent + 1;
            end
        end
    end
endmodule // vc4_and_tributary_model

// >>> vc11_into_tu12_adapt_source_test.sv
// Self-checking bench for the VC-11 into TU-12 source adaptation.
// Assumes the far side model supplies VC-4 timing and the tributary stream.
module vc11_into_tu12_adapt_source_test;
    timeunit 1ns;
    timeprecision 1ps;
    reg clock = 1'b0;
    reg reset, upstream_signal_fail_in, slot_activation_control;
    reg [1:0] slot_k, slot_m;
    reg [2:0] slot_l;
    wire ho_clock, ho_frame, ho_multiframe, trib_clock, trib_data, trib_frame, frame_mark, multiframe_mark;
    wire [7:0] slot_data_out;
    wire slot_data_enable, alarm_indication_action, pointer_locked;
    wire [9:0] pointer_value;
    int num_errors = 0;
    int checked = 0;
    // Free running 50 MHz clock.
    always #10 clock = ~clock;
    vc4_and_tributary_model far_end (.clock(clock), .reset(reset), .higher_order_clock_in(ho_clock),
        .higher_order_frame_start(ho_frame), .higher_order_multiframe_start(ho_multiframe),
        .tributary_clock_in(trib_clock), .tributary_data_in(trib_data), .tributary_frame_start_in(trib_frame),
        .frame_mark(frame_mark), .multiframe_mark(multiframe_mark));
    vc11_into_tu12_adapt_source uut (.clock(clock), .reset(reset), .tributary_clock_in(trib_clock),
        .tributary_data_in(trib_data), .tributary_frame_start_in(trib_frame),
        .upstream_signal_fail_in(upstream_signal_fail_in), .higher_order_clock_in(ho_clock),
        .higher_order_frame_start(ho_frame), .higher_order_multiframe_start(ho_multiframe),
        .slot_activation_control(slot_activation_control), .slot_k(slot_k), .slot_l(slot_l), .slot_m(slot_m),
        .slot_data_out(slot_data_out), .slot_data_enable(slot_data_enable),
        .alarm_indication_action(alarm_indication_action), .pointer_locked(pointer_locked),
        .pointer_value(pointer_value));
    task automatic check(input [9:0] seen, input [9:0] expected);
        checked++;
        if (seen !== expected) begin
            num_errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic give_up;
        num_errors++;
        $display("Error at %0t ns: wait ran out", $time);
        test_done();
    endtask
    task automatic next_byte(output [7:0] b);
        int t = 0;
        do begin
            @(posedge clock);
            t++;
            if (t > 4000) give_up();
        end while (slot_data_enable !== 1'b1);
        b = slot_data_out;
    endtask
    task automatic count_frame(output int n);
        int t = 0;
        n = 0;
        do begin
            @(posedge clock);
            if (slot_data_enable === 1'b1) n++;
            t++;
            if (t > 10000) give_up();
        end while (frame_mark !== 1'b1);
    endtask
    task automatic test_activation;
        int n;
        count_frame(n);
        check(n, 0);
        slot_activation_control <= 1'b1;
        count_frame(n);
        check(n, 36);
        $display("activation test done");
    endtask
    task automatic test_multiframe;
        reg [7:0] b [0:108];
        reg [9:0] p, w;
        int rel, t;
        t = 0;
        while (multiframe_mark !== 1'b1) begin
            @(posedge clock);
            t++;
            if (t > 40000) give_up();
        end
        p = pointer_value;
        check(pointer_locked, 1'b1);
        for (int i = 0; i < 109; i++) next_byte(b[i]);
        check(b[0][3:2], 2'b10);
        check(b[0][7:4], 4'h9);
        w = {b[0][1:0], b[36]};
        for (int o = 0; o < 35; o++) begin
            rel = (o + 140 - p) % 140;
            if (rel == 0) check(b[37 + o], 8'hc3);
            else if (rel % 35 >= 17 && rel % 35 <= 25) check(b[37 + o], 8'h00);
            else check(b[37 + o], 8'h5a);
        end
        if (w === (p ^ 10'h2aa)) begin
            check(b[73], 8'h00);
            check(pointer_value, (p + 1) % 140);
        end else if (w === (p ^ 10'h155)) begin
            check(b[72], 8'h5a);
            check(pointer_value, (p + 139) % 140);
        end else begin
            check(w, p);
            check(pointer_value, p);
        end
        $display("multiframe test done");
    endtask
    task automatic test_alarm;
        reg [7:0] b;
        int t = 0;
        upstream_signal_fail_in <= 1'b1;
        repeat (80) @(posedge clock);
        check(alarm_indication_action, 1'b1);
        repeat (4) begin
            next_byte(b);
            check(b, 8'hff);
        end
        upstream_signal_fail_in <= 1'b0;
        repeat (10) @(posedge clock);
        check(alarm_indication_action, 1'b0);
        while (pointer_locked !== 1'b1) begin
            @(posedge clock);
            t++;
            if (t > 50000) give_up();
        end
        check(pointer_locked, 1'b1);
        $display("alarm test done");
    endtask
    // Main sequence: reset for 16 cycles, then each scenario in turn.
    initial begin
        reset <= 1'b1;
        upstream_signal_fail_in <= 1'b0;
        slot_activation_control <= 1'b0;
        slot_k <= 2'd2;
        slot_l <= 3'd3;
        slot_m <= 2'd2;
        repeat (16) @(posedge clock);
        check(slot_data_out, 8'hff);
        check(slot_data_enable, 1'b0);
        check(pointer_value, 10'h000);
        reset <= 1'b0;
        test_activation();
        test_multiframe();
        test_alarm();
        test_done();
    end
endmodule // vc11_into_tu12_adapt_source_test
